// >>> hw/core_consts.svh
// constants for the data, bit and core-control execution block
`ifndef CORE_CONSTS_SVH
`define CORE_CONSTS_SVH

// status register bit positions
`define SR_C 0
`define SR_Z 1
`define SR_N 2
`define SR_V 3
`define SR_S 4
`define SR_H 5
`define SR_T 6
`define SR_I 7

// reset values
`define SR_RESET 8'h00
`define SP_RESET 16'h00FF

// cycle counts per operation class
`define PM_LOAD_CYCLES 3
`define STACK_CYCLES 2
`define IO_BIT_CYCLES 2
`define SINGLE_CYCLES 1

`endif

// >>> hw/core_ops_pkg.sv
// types shared by the data, bit and core-control execution block
package core_ops_pkg;

   typedef enum logic [4:0] {
      op_no_operation,
      op_program_memory_load,
      op_program_memory_load_inc,
      op_push,
      op_pop,
      op_io_bit_set,
      op_io_bit_clear,
      op_logical_shift_left,
      op_logical_shift_right,
      op_rotate_left_via_carry,
      op_rotate_right_via_carry,
      op_arith_shift_right,
      op_reg_bit_to_t_flag,
      op_t_flag_to_reg_bit,
      op_flag_set,
      op_flag_clear,
      op_sleep,
      op_watchdog_restart,
      op_break
   } op_e;

   typedef enum logic [2:0] {
      st_idle,
      st_pm_wait,
      st_pm_data,
      st_stack_end,
      st_pop_data,
      st_io_modify,
      st_debug_halt
   } exec_state_e;

endpackage

// >>> hw/shift_unit.sv
// shift and rotate datapath with its zero, carry, negative and overflow results
`timescale 1ns/10ps
module shift_unit #(
   parameter int WIDTH = 8
) (
   // operation
   input wire core_ops_pkg::op_e op,
   input wire logic [WIDTH-1:0] din,
   input wire logic carry_in,
   // result
   output logic [WIDTH-1:0] dout,
   output logic carry_out,
   output logic zero,
   output logic negative,
   output logic overflow
);
   import core_ops_pkg::*;

   always_comb begin
      dout = din;
      carry_out = carry_in;
      case (op)
         op_logical_shift_left: begin
            dout = {din[WIDTH-2:0], 1'b0};
            carry_out = din[WIDTH-1];
         end
         op_logical_shift_right: begin
            dout = {1'b0, din[WIDTH-1:1]};
            carry_out = din[0];
         end
         op_rotate_left_via_carry: begin
            dout = {din[WIDTH-2:0], carry_in};
            carry_out = din[WIDTH-1];
         end
         op_rotate_right_via_carry: begin
            dout = {carry_in, din[WIDTH-1:1]};
            carry_out = din[0];
         end
         op_arith_shift_right: begin
            dout = {din[WIDTH-1], din[WIDTH-1:1]};
            carry_out = din[0];
         end
         default: begin
            dout = din;
            carry_out = carry_in;
         end
      endcase
      zero = (dout == '0);
      negative = dout[WIDTH-1];
      // overflow after a shift is negative xor carry
      overflow = dout[WIDTH-1] ^ carry_out;
   end

endmodule

// >>> hw/core_data_bit_ctrl_ops.sv
// execution unit for program-memory load, stack, i/o bit, shift, flag and control ops
//
// Functional notes
// - program_memory_load copies byte at Z to register in 3 cycles; post-inc bumps Z
// - push writes stack, pop reads stack; two cycles each, flags unchanged
// - io_bit_set and io_bit_clear force one i/o register bit; two cycles
// - logical_shift_left shifts up, zero into bit 0; one cycle; Z,C,N,V
// - logical_shift_right shifts down, zero into bit 7; one cycle; Z,C,N,V
// - rotate_left_via_carry: old carry to bit 0, bit 7 to carry; one cycle
// - rotate_right_via_carry: old carry to bit 7, bit 0 to carry; one cycle
// - reg_bit_to_t_flag copies a source bit into T in one cycle
// - t_flag_to_reg_bit copies T into a destination bit; one cycle, no flags
// - single-cycle set and clear of the signed test flag or any other flag_sel bit
// - single-cycle set and clear of the overflow flag or any other flag_sel bit
// - single-cycle set and clear of the half carry flag or any other flag_sel bit
// - sleep issues in one cycle, flags unchanged, then requests low power
// - watchdog_restart takes one cycle, flags unchanged, restarts the watchdog
// - break is for on-chip debug, no fixed cycle count, no flags
`timescale 1ns/10ps
`include "core_consts.svh"
module core_data_bit_ctrl_ops #(
   parameter int DATA_W = 8,
   parameter int ADDR_W = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // operation request
   input wire logic op_valid,
   input wire core_ops_pkg::op_e op_code,
   input wire logic [DATA_W-1:0] src_data,
   input wire logic [4:0] dst_idx,
   input wire logic [2:0] bit_sel,
   input wire logic [2:0] flag_sel,
   input wire logic [5:0] io_sel,
   input wire logic [ADDR_W-1:0] z_in,
   input wire logic debug_resume,
   // progress and state
   output logic busy,
   output logic done,
   output logic [7:0] status_register,
   output logic [ADDR_W-1:0] stack_ptr,
   // register file write-back
   output logic rf_we,
   output logic [4:0] rf_idx,
   output logic [DATA_W-1:0] rf_data,
   output logic z_we,
   output logic [ADDR_W-1:0] z_data,
   // program memory read port
   output logic pmem_rd,
   output logic [ADDR_W-2:0] pmem_addr,
   input wire logic [15:0] pmem_rdata,
   // data memory port for the stack
   output logic dmem_rd,
   output logic dmem_we,
   output logic [ADDR_W-1:0] dmem_addr,
   output logic [DATA_W-1:0] dmem_wdata,
   input wire logic [DATA_W-1:0] dmem_rdata,
   // i/o register port
   output logic io_rd,
   output logic io_we,
   output logic [5:0] io_addr,
   output logic [DATA_W-1:0] io_wdata,
   input wire logic [DATA_W-1:0] io_rdata,
   // core control
   output logic sleep_req,
   output logic wdt_restart,
   output logic break_req
);
   import core_ops_pkg::*;

   // ****************************************
   // shift datapath
   // ****************************************
   logic [DATA_W-1:0] sh_dout;
   logic sh_c;
   logic sh_z;
   logic sh_n;
   logic sh_v;

   shift_unit #(.WIDTH(DATA_W)) u_shift (
      .op(op_code),
      .din(src_data),
      .carry_in(status_register[`SR_C]),
      .dout(sh_dout),
      .carry_out(sh_c),
      .zero(sh_z),
      .negative(sh_n),
      .overflow(sh_v)
   );

   // ****************************************
   // sequencing
   // ****************************************
   exec_state_e state, next_state;
   logic [2:0] bit_hold, next_bit_hold;
   logic set_hold, next_set_hold;
   logic inc_hold, next_inc_hold;
   logic [ADDR_W-1:0] z_hold, next_z_hold;
   logic next_busy, next_done, next_rf_we, next_z_we;
   logic next_pmem_rd, next_dmem_rd, next_dmem_we, next_io_rd, next_io_we;
   logic next_sleep_req, next_wdt_restart, next_break_req;
   logic [7:0] next_status;
   logic [ADDR_W-1:0] next_sp, next_z_data, next_dmem_addr;
   logic [ADDR_W-2:0] next_pmem_addr;
   logic [4:0] next_rf_idx;
   logic [DATA_W-1:0] next_rf_data, next_dmem_wdata, next_io_wdata;
   logic [5:0] next_io_addr;
   logic take;
   logic [DATA_W-1:0] bit_mask;

   assign take = op_valid && (state == st_idle);
   assign bit_mask = DATA_W'(1) << bit_hold;

   always_comb begin
      next_state = state;
      next_bit_hold = bit_hold;
      next_set_hold = set_hold;
      next_inc_hold = inc_hold;
      next_z_hold = z_hold;
      next_status = status_register;
      next_sp = stack_ptr;
      next_rf_idx = rf_idx;
      next_rf_data = rf_data;
      next_z_data = z_data;
      next_pmem_addr = pmem_addr;
      next_dmem_addr = dmem_addr;
      next_dmem_wdata = dmem_wdata;
      next_io_addr = io_addr;
      next_io_wdata = io_wdata;
      next_done = 1'b0;
      next_rf_we = 1'b0;
      next_z_we = 1'b0;
      next_pmem_rd = 1'b0;
      next_dmem_rd = 1'b0;
      next_dmem_we = 1'b0;
      next_io_rd = 1'b0;
      next_io_we = 1'b0;
      next_sleep_req = 1'b0;
      next_wdt_restart = 1'b0;
      next_break_req = 1'b0;
      case (state)
         st_idle: begin
            if (op_valid) begin
               next_rf_idx = dst_idx;
               next_bit_hold = bit_sel;
               case (op_code)
                  op_program_memory_load, op_program_memory_load_inc: begin
                     next_z_hold = z_in;
                     next_inc_hold = (op_code == op_program_memory_load_inc);
                     next_pmem_addr = z_in[ADDR_W-1:1];
                     next_pmem_rd = 1'b1;
                     next_state = st_pm_wait;
                  end
                  op_push: begin
                     next_dmem_addr = stack_ptr;
                     next_dmem_wdata = src_data;
                     next_dmem_we = 1'b1;
                     next_sp = stack_ptr - ADDR_W'(1);
                     next_state = st_stack_end;
                  end
                  op_pop: begin
                     next_sp = stack_ptr + ADDR_W'(1);
                     next_dmem_addr = stack_ptr + ADDR_W'(1);
                     next_dmem_rd = 1'b1;
                     next_state = st_pop_data;
                  end
                  op_io_bit_set, op_io_bit_clear: begin
                     next_set_hold = (op_code == op_io_bit_set);
                     next_io_addr = io_sel;
                     next_io_rd = 1'b1;
                     next_state = st_io_modify;
                  end
                  op_logical_shift_left, op_logical_shift_right, op_rotate_left_via_carry,
                  op_rotate_right_via_carry, op_arith_shift_right: begin
                     next_rf_data = sh_dout;
                     next_rf_we = 1'b1;
                     next_status[`SR_C] = sh_c;
                     next_status[`SR_Z] = sh_z;
                     next_status[`SR_N] = sh_n;
                     next_status[`SR_V] = sh_v;
                     next_done = 1'b1;
                  end
                  op_reg_bit_to_t_flag: begin
                     next_status[`SR_T] = src_data[bit_sel];
                     next_done = 1'b1;
                  end
                  op_t_flag_to_reg_bit: begin
                     next_rf_data = src_data;
                     next_rf_data[bit_sel] = status_register[`SR_T];
                     next_rf_we = 1'b1;
                     next_done = 1'b1;
                  end
                  op_flag_set, op_flag_clear: begin
                     next_status[flag_sel] = (op_code == op_flag_set);
                     next_done = 1'b1;
                  end
                  op_sleep: begin
                     next_sleep_req = 1'b1;
                     next_done = 1'b1;
                  end
                  op_watchdog_restart: begin
                     next_wdt_restart = 1'b1;
                     next_done = 1'b1;
                  end
                  op_break: begin
                     // break_req pulses for one cycle; st_debug_halt is held until the debugger lets go
                     next_break_req = 1'b1;
                     next_state = st_debug_halt;
                  end
                  default: begin
                     next_done = 1'b1;
                  end
               endcase
            end
         end
         st_pm_wait: begin
            next_pmem_rd = 1'b1;
            next_state = st_pm_data;
         end
         st_pm_data: begin
            // bit 0 of the pointer picks the byte of the program word
            next_rf_data = z_hold[0] ? pmem_rdata[15:8] : pmem_rdata[7:0];
            next_rf_we = 1'b1;
            next_z_data = z_hold + ADDR_W'(1);
            next_z_we = inc_hold;
            next_done = 1'b1;
            next_state = st_idle;
         end
         st_stack_end: begin
            next_done = 1'b1;
            next_state = st_idle;
         end
         st_pop_data: begin
            next_rf_data = dmem_rdata;
            next_rf_we = 1'b1;
            next_done = 1'b1;
            next_state = st_idle;
         end
         st_io_modify: begin
            // read-modify-write of the addressed i/o register
            next_io_wdata = set_hold ? (io_rdata | bit_mask) : (io_rdata & ~bit_mask);
            next_io_we = 1'b1;
            next_done = 1'b1;
            next_state = st_idle;
         end
         st_debug_halt: begin
            if (debug_resume) begin
               next_done = 1'b1;
               next_state = st_idle;
            end
         end
         default: begin
            next_state = st_idle;
         end
      endcase
      next_busy = (next_state != st_idle);
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state <= st_idle;
         bit_hold <= 3'h0;
         set_hold <= 1'b0;
         inc_hold <= 1'b0;
         z_hold <= '0;
         status_register <= `SR_RESET;
         stack_ptr <= `SP_RESET;
         busy <= 1'b0;
         done <= 1'b0;
         rf_we <= 1'b0;
         rf_idx <= 5'h00;
         rf_data <= '0;
         z_we <= 1'b0;
         z_data <= '0;
         pmem_rd <= 1'b0;
         pmem_addr <= '0;
         dmem_rd <= 1'b0;
         dmem_we <= 1'b0;
         dmem_addr <= '0;
         dmem_wdata <= '0;
         io_rd <= 1'b0;
         io_we <= 1'b0;
         io_addr <= 6'h00;
         io_wdata <= '0;
         sleep_req <= 1'b0;
         wdt_restart <= 1'b0;
         break_req <= 1'b0;
      end else begin
         state <= next_state;
         bit_hold <= next_bit_hold;
         set_hold <= next_set_hold;
         inc_hold <= next_inc_hold;
         z_hold <= next_z_hold;
         status_register <= next_status;
         stack_ptr <= next_sp;
         busy <= next_busy;
         done <= next_done;
         rf_we <= next_rf_we;
         rf_idx <= next_rf_idx;
         rf_data <= next_rf_data;
         z_we <= next_z_we;
         z_data <= next_z_data;
         pmem_rd <= next_pmem_rd;
         pmem_addr <= next_pmem_addr;
         dmem_rd <= next_dmem_rd;
         dmem_we <= next_dmem_we;
         dmem_addr <= next_dmem_addr;
         dmem_wdata <= next_dmem_wdata;
         io_rd <= next_io_rd;
         io_we <= next_io_we;
         io_addr <= next_io_addr;
         io_wdata <= next_io_wdata;
         sleep_req <= next_sleep_req;
         wdt_restart <= next_wdt_restart;
         break_req <= next_break_req;
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   pm_load_timing_a: assert property (take && op_code == op_program_memory_load
      |-> !done ##1 !done ##1 !done ##1 (done && rf_we && status_register == $past(status_register, 3)))
      else $error("program memory load not done in three cycles");
   pm_post_inc_a: assert property (take && op_code == op_program_memory_load_inc
      |-> ##3 (z_we && z_data == ADDR_W'($past(z_in, 3) + ADDR_W'(1))))
      else $error("post-increment did not bump Z");
   push_timing_a: assert property (take && op_code == op_push
      |-> ##1 (dmem_we && dmem_wdata == $past(src_data)) ##1 (done && !dmem_we))
      else $error("push not written or not two cycles");
   pop_timing_a: assert property (take && op_code == op_pop
      |-> ##1 (dmem_rd && !done) ##1 (done && rf_we && $stable(status_register)))
      else $error("pop not completed in two cycles");
   io_bit_set_a: assert property (take && op_code == op_io_bit_set
      |-> ##2 (io_we && done && io_wdata[$past(bit_sel, 2)] == 1'b1))
      else $error("i/o bit not set");
   io_bit_clear_a: assert property (take && op_code == op_io_bit_clear
      |-> ##2 (io_we && done && io_wdata[$past(bit_sel, 2)] == 1'b0))
      else $error("i/o bit not cleared");
   shl_result_a: assert property (take && op_code == op_logical_shift_left
      |=> (rf_data == {$past(src_data[DATA_W-2:0]), 1'b0}
           && status_register[`SR_C] == $past(src_data[DATA_W-1]) && done))
      else $error("logical shift left wrong");
   shr_result_a: assert property (take && op_code == op_logical_shift_right
      |=> (rf_data == {1'b0, $past(src_data[DATA_W-1:1])}
           && status_register[`SR_N] == 1'b0 && done))
      else $error("logical shift right wrong");
   rol_carry_a: assert property (take && op_code == op_rotate_left_via_carry
      |=> (rf_data[0] == $past(status_register[`SR_C])
           && status_register[`SR_C] == $past(src_data[DATA_W-1])))
      else $error("rotate left through carry wrong");
   ror_carry_a: assert property (take && op_code == op_rotate_right_via_carry
      |=> (rf_data[DATA_W-1] == $past(status_register[`SR_C])
           && status_register[`SR_C] == $past(src_data[0])))
      else $error("rotate right through carry wrong");
   asr_sign_a: assert property (take && op_code == op_arith_shift_right
      |=> (rf_data == {$past(src_data[DATA_W-1]), $past(src_data[DATA_W-1:1])}
           && status_register[`SR_C] == $past(src_data[0])
           && status_register[`SR_V] == ($past(src_data[DATA_W-1]) ^ $past(src_data[0]))))
      else $error("arithmetic shift right wrong");
   bit_to_t_a: assert property (take && op_code == op_reg_bit_to_t_flag
      |=> (status_register[`SR_T] == $past(src_data[bit_sel]) && !rf_we && done))
      else $error("T flag not loaded from register bit");
   t_to_bit_a: assert property (take && op_code == op_t_flag_to_reg_bit
      |=> (rf_we && rf_data[$past(bit_sel)] == $past(status_register[`SR_T])
           && $stable(status_register)))
      else $error("register bit not loaded from T flag");
   flag_set_a: assert property (take && op_code == op_flag_set
      |=> (status_register == ($past(status_register) | (8'h01 << $past(flag_sel)))))
      else $error("flag set touched the wrong bits");
   flag_clear_a: assert property (take && op_code == op_flag_clear
      |=> (status_register == ($past(status_register) & ~(8'h01 << $past(flag_sel)))))
      else $error("flag clear touched the wrong bits");
   sleep_issue_a: assert property (take && op_code == op_sleep
      |=> (sleep_req && done && !busy && $stable(status_register)))
      else $error("sleep not issued in one cycle");
   wdt_issue_a: assert property (take && op_code == op_watchdog_restart
      |=> (wdt_restart && done && $stable(status_register)))
      else $error("watchdog restart not issued in one cycle");
   break_halt_a: assert property (take && op_code == op_break
      |=> (break_req && busy && !done) ##1 ((busy || done) && $stable(status_register)))
      else $error("break did not halt for debug");

   pm_load_c: cover property (take && op_code == op_program_memory_load_inc ##3 done);
   push_pop_c: cover property (take && op_code == op_push ##2 take && op_code == op_pop);
   io_set_c: cover property (take && op_code == op_io_bit_set ##2 io_we);
   break_resume_c: cover property (break_req ##[1:20] (debug_resume && busy));

endmodule

// >>> sim/tb_core_data_bit_ctrl_ops.sv
// self-checking random testbench for the data, bit and core-control execution block
`timescale 1ns/10ps
`include "core_consts.svh"
module tb_core_data_bit_ctrl_ops;
   import core_ops_pkg::*;
   // ********************
   // stimulus and observed signals
   // ********************
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic op_valid = 1'b0;
   logic debug_resume = 1'b0;
   op_e op_code = op_no_operation;
   logic [7:0] src_data = 8'h00;
   logic [7:0] dmem_rdata = 8'h00;
   logic [7:0] io_rdata = 8'h00;
   logic [4:0] dst_idx = 5'h00;
   logic [2:0] bit_sel = 3'h0;
   logic [2:0] flag_sel = 3'h0;
   logic [5:0] io_sel = 6'h00;
   logic [15:0] z_in = 16'h0000;
   logic [15:0] pmem_rdata = 16'h0000;
   logic busy, done, rf_we, z_we, pmem_rd, dmem_rd, dmem_we, io_rd, io_we;
   logic sleep_req, wdt_restart, break_req;
   logic [7:0] status_register, rf_data, dmem_wdata, io_wdata;
   logic [15:0] stack_ptr, z_data, dmem_addr;
   logic [4:0] rf_idx;
   logic [14:0] pmem_addr;
   logic [5:0] io_addr;
   int error_cnt = 0;
   int n_tests = 0;
   int cyc = 0;
   int seed = 18;
   logic [7:0] esr = 8'h00;
   logic [15:0] esp = 16'h00FF;

   core_data_bit_ctrl_ops #(.DATA_W(8), .ADDR_W(16)) i_dut (
      .clk(clk), .sys_rst(sys_rst), .op_valid(op_valid), .op_code(op_code),
      .src_data(src_data), .dst_idx(dst_idx), .bit_sel(bit_sel), .flag_sel(flag_sel),
      .io_sel(io_sel), .z_in(z_in), .debug_resume(debug_resume), .busy(busy), .done(done),
      .status_register(status_register), .stack_ptr(stack_ptr), .rf_we(rf_we),
      .rf_idx(rf_idx), .rf_data(rf_data), .z_we(z_we), .z_data(z_data), .pmem_rd(pmem_rd),
      .pmem_addr(pmem_addr), .pmem_rdata(pmem_rdata), .dmem_rd(dmem_rd), .dmem_we(dmem_we),
      .dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata), .dmem_rdata(dmem_rdata),
      .io_rd(io_rd), .io_we(io_we), .io_addr(io_addr), .io_wdata(io_wdata),
      .io_rdata(io_rdata), .sleep_req(sleep_req), .wdt_restart(wdt_restart),
      .break_req(break_req)
   );

   always #50 clk = ~clk;

   // ********************
   // helpers
   // ********************
   task automatic test_done;
      $display("errors=%0d checks=%0d", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == 6000) begin
         error_cnt++;
         test_done;
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         error_cnt++;
      end
   endtask

   // result in [7:0], then C, Z, N, V
   function automatic logic [11:0] shift_exp(input op_e op, input logic [7:0] d, input logic c);
      logic [7:0] r;
      logic co;
      case (op)
         op_logical_shift_left: begin r = {d[6:0], 1'b0}; co = d[7]; end
         op_logical_shift_right: begin r = {1'b0, d[7:1]}; co = d[0]; end
         op_rotate_left_via_carry: begin r = {d[6:0], c}; co = d[7]; end
         op_rotate_right_via_carry: begin r = {c, d[7:1]}; co = d[0]; end
         default: begin r = {d[7], d[7:1]}; co = d[0]; end
      endcase
      return {r[7] ^ co, r[7], r == 8'h00, co, r};
   endfunction

   function automatic int cyc_exp(input op_e op);
      if (op == op_program_memory_load || op == op_program_memory_load_inc) return `PM_LOAD_CYCLES;
      if (op == op_push || op == op_pop) return `STACK_CYCLES;
      if (op == op_io_bit_set || op == op_io_bit_clear) return `IO_BIT_CYCLES;
      return `SINGLE_CYCLES;
   endfunction

   task automatic reset_check;
      chk(status_register, `SR_RESET);
      chk(stack_ptr, `SP_RESET);
      chk(busy, 1'b0);
      esr = `SR_RESET;
      esp = `SP_RESET;
   endtask

   task automatic run_op(input op_e op);
      int n;
      logic [5:0] seen, eseen;
      logic [2:0] rd_seen, erd;
      logic [7:0] erf;
      logic [15:0] dadr, padr;
      logic [11:0] sh;
      @(posedge clk);
      op_valid <= 1'b1;
      op_code <= op;
      src_data <= (n_tests % 5 == 0) ? 8'h80 : 8'($random(seed));
      dst_idx <= 5'($random(seed));
      bit_sel <= 3'($random(seed));
      flag_sel <= 3'($random(seed));
      io_sel <= 6'($random(seed));
      z_in <= 16'($random(seed));
      pmem_rdata <= 16'($random(seed));
      dmem_rdata <= 8'($random(seed));
      io_rdata <= 8'($random(seed));
      @(posedge clk);
      op_valid <= 1'b0;
      seen = 6'h00;
      rd_seen = 3'h0;
      n = 0;
      while (1) begin
         #1;
         n++;
         seen |= {wdt_restart, sleep_req, io_we, dmem_we, z_we, rf_we};
         rd_seen |= {io_rd, dmem_rd, pmem_rd};
         if (n == 1) chk(16'(busy), 16'(cyc_exp(op) > 1));
         if (dmem_rd || dmem_we) dadr = dmem_addr;
         if (pmem_rd) padr = {1'b0, pmem_addr};
         if (done === 1'b1 || n >= 20) break;
         @(posedge clk);
      end
      erf = 8'h00;
      eseen = 6'h00;
      erd = 3'h0;
      case (op)
         op_program_memory_load, op_program_memory_load_inc: begin
            erf = z_in[0] ? pmem_rdata[15:8] : pmem_rdata[7:0];
            eseen = (op == op_program_memory_load_inc) ? 6'h03 : 6'h01;
            erd = 3'h1;
            chk(padr, {1'b0, z_in[15:1]});
            if (eseen[1]) chk(z_data, z_in + 16'h0001);
         end
         op_push: begin
            eseen = 6'h04;
            chk(dmem_wdata, src_data);
            chk(dadr, esp);
            esp = esp - 16'h0001;
         end
         op_pop: begin
            esp = esp + 16'h0001;
            eseen = 6'h01;
            erd = 3'h2;
            erf = dmem_rdata;
            chk(dadr, esp);
         end
         op_io_bit_set, op_io_bit_clear: begin
            eseen = 6'h08;
            erd = 3'h4;
            erf = (op == op_io_bit_set) ? io_rdata | (8'h01 << bit_sel)
                                        : io_rdata & ~(8'h01 << bit_sel);
            chk(io_wdata, erf);
            chk(io_addr, io_sel);
         end
         op_logical_shift_left, op_logical_shift_right, op_rotate_left_via_carry,
         op_rotate_right_via_carry, op_arith_shift_right: begin
            sh = shift_exp(op, src_data, esr[`SR_C]);
            erf = sh[7:0];
            {esr[`SR_V], esr[`SR_N], esr[`SR_Z], esr[`SR_C]} = sh[11:8];
            eseen = 6'h01;
         end
         op_reg_bit_to_t_flag: esr[`SR_T] = src_data[bit_sel];
         op_t_flag_to_reg_bit: begin
            erf = src_data;
            erf[bit_sel] = esr[`SR_T];
            eseen = 6'h01;
         end
         op_flag_set: esr[flag_sel] = 1'b1;
         op_flag_clear: esr[flag_sel] = 1'b0;
         op_sleep: eseen = 6'h10;
         op_watchdog_restart: eseen = 6'h20;
         default: ;
      endcase
      chk(16'(n), 16'(cyc_exp(op)));
      chk(seen, eseen);
      chk(rd_seen, erd);
      if (eseen[0]) chk(rf_data, erf);
      if (eseen[0]) chk(rf_idx, dst_idx);
      chk(status_register, esr);
      chk(stack_ptr, esp);
   endtask

   // ********************
   // main sequence
   // ********************
   initial begin
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      #1;
      reset_check;
      for (int i = 0; i < 240; i++) begin
         if (i == 120) begin
            @(posedge clk);
            sys_rst <= 1'b1;
            repeat (2) @(posedge clk);
            sys_rst <= 1'b0;
            #1;
            reset_check;
         end
         run_op((i < 18) ? op_e'(i) : op_e'($unsigned($random(seed)) % 18));
      end
      // break halt, with a request during the halt that must be ignored
      @(posedge clk);
      op_valid <= 1'b1;
      op_code <= op_break;
      @(posedge clk);
      op_code <= op_flag_set;
      flag_sel <= 3'h7;
      #1;
      chk(break_req, 1'b1);
      repeat (4) @(posedge clk);
      #1;
      chk(busy, 1'b1);
      chk(done, 1'b0);
      @(posedge clk);
      op_valid <= 1'b0;
      debug_resume <= 1'b1;
      @(posedge clk);
      debug_resume <= 1'b0;
      #1;
      chk(done, 1'b1);
      chk(status_register, esr);
      repeat (3) @(posedge clk);
      test_done;
   end
endmodule
